// ---- asq_consts.vh ----
// constants for the sample sequencer control block
// assumes an apb master on pclk and one shared converter core
// Summary of operation
// - four sequencers: 8, 4, 4, 1 steps/entries
// - fifo word 32 bits, result low 10
// - each step: input nibble plus control nibble
// - sequencer starts only when enabled; config anytime
// - step interrupt after any flagged step
// - end bit stops sequence after that step
// - fifo read pops oldest entry
// - head, tail, full, empty readable per fifo
// - overflow and underflow flagged per sequencer
// - interrupt output only for masked-in sequencers
// - raw status, masked status equals raw and mask
// - write one to masked status clears pending
// - concurrent triggers served by priority, 0 highest
// - per-sequencer trigger select, software and always
// - initiate register bit starts software-triggered sequencer
// - average up to 64 conversions into one entry
// - averaging off at reset, shared by all
// - single-ended result spans 0x000 to 0x3ff
// - differential pair k uses inputs 2k, 2k+1
// - differential result offset-coded around 0x1ff
// - loopback mode runs without analog stimulus
// - priority reset: each sequencer equals its index
`ifndef ASQ_CONSTS_VH
`define ASQ_CONSTS_VH
`define ASQ_OFF_ACT 12'h000
`define ASQ_OFF_RIS 12'h004
`define ASQ_OFF_IM 12'h008
`define ASQ_OFF_ISC 12'h00c
`define ASQ_OFF_OVF 12'h010
`define ASQ_OFF_TRIG 12'h014
`define ASQ_OFF_UNF 12'h018
`define ASQ_OFF_PRI 12'h020
`define ASQ_OFF_INIT 12'h028
`define ASQ_OFF_AVG 12'h030
`define ASQ_OFF_LB 12'h100
`define ASQ_SEQ_BASE 3'h2
`define ASQ_SUB_MUX 3'h0
`define ASQ_SUB_CTL 3'h1
`define ASQ_SUB_FIFO 3'h2
`define ASQ_SUB_STAT 3'h3
`define ASQ_PRI_RST 16'h3210
`define ASQ_PRI_MASK 16'h3333
`define ASQ_CTL3_RST 32'h00000002
`define ASQ_CTL_DIFF 0
`define ASQ_CTL_END 1
`define ASQ_CTL_IE 2
`define ASQ_CTL_TEMP 3
`define ASQ_TRIG_SW 4'h0
`define ASQ_TRIG_EXT 4'h1
`define ASQ_TRIG_ALWAYS 4'hf
`define ASQ_AVG_MAX 3'h6
`define ASQ_ST_EMPTY 8
`define ASQ_ST_FULL 12
`endif

// ---- asq_ctrl.v ----
// sample sequencer control: apb registers, arbiter, step engine, fifos
// assumes one converter core: start pulse in, done pulse with result out
`timescale 1ns/100ps
`default_nettype none
`include "asq_consts.vh"
module asq_ctrl #(
  parameter RES_W = 10
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [3:0] trig_in,
  output reg conv_start,
  output reg [3:0] conv_input,
  output reg conv_diff,
  output reg conv_temp,
  input wire conv_done,
  input wire [RES_W-1:0] conv_result,
  output wire irq
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_STORE = 4'b1000;

  function [3:0] seq_depth;
    input [1:0] s;
    begin
      case (s)
        2'd0: seq_depth = 4'd8;
        2'd1: seq_depth = 4'd4;
        2'd2: seq_depth = 4'd4;
        default: seq_depth = 4'd1;
      endcase
    end
  endfunction

  reg [3:0] act_q, ris_q, im_q, ovf_q, unf_q, pend_q;
  reg [15:0] trig_q, pri_q;
  reg [2:0] avg_q;
  reg lb_q;
  reg [31:0] mux_q [0:3];
  reg [31:0] ctl_q [0:3];
  reg [RES_W-1:0] mem_q [0:31];
  reg [2:0] head_q [0:3];
  reg [2:0] tail_q [0:3];
  reg [3:0] cnt_q [0:3];
  reg [3:0] state_q;
  reg [1:0] cur_q;
  reg [2:0] step_q;
  reg [6:0] avgc_q;
  reg [15:0] acc_q;
  reg [RES_W-1:0] lbv_q;

  wire setup = psel & ~penable;
  wire acc_ph = psel & penable;
  wire wr = acc_ph & pwrite;
  wire rd = acc_ph & ~pwrite;
  wire in_seq = (paddr[11:8] == 4'h0) && (paddr[7:5] >= `ASQ_SEQ_BASE)
    && (paddr[7:5] < 3'h6) && (paddr[1:0] == 2'b00) && !paddr[4];
  wire [1:0] aseq = paddr[6:5] - 2'd2;
  wire [2:0] asub = paddr[4:2];

  // zero wait state slave
  assign pready = 1'b1;

  // priority arbiter over enabled sequencers with a pending trigger
  reg [3:0] ready_v;
  reg found;
  reg [1:0] win, winp;
  integer i;
  // one loop index per process so no variable has two drivers
  integer ti;
  integer ri;
  integer fi;
  always @* begin
    ready_v = pend_q & act_q;
    found = 1'b0;
    win = 2'd0;
    winp = 2'd3;
    for (i = 0; i < 4; i = i + 1) begin
      if (ready_v[i] && (!found || pri_q[4*i +: 2] < winp)) begin
        found = 1'b1;
        win = i[1:0];
        winp = pri_q[4*i +: 2];
      end
    end
  end

  // trigger sources
  reg [3:0] trig_v;
  always @* begin
    for (ti = 0; ti < 4; ti = ti + 1) begin
      case (trig_q[4*ti +: 4])
        `ASQ_TRIG_SW: trig_v[ti] = wr && paddr == `ASQ_OFF_INIT
          && pwdata[ti];
        `ASQ_TRIG_EXT: trig_v[ti] = trig_in[ti];
        `ASQ_TRIG_ALWAYS: trig_v[ti] = 1'b1;
        default: trig_v[ti] = 1'b0;
      endcase
    end
  end

  // current step fields
  wire [3:0] in_nib = mux_q[cur_q][4*step_q +: 4];
  wire [3:0] ct_nib = ctl_q[cur_q][4*step_q +: 4];
  wire [2:0] avg_n = (avg_q > `ASQ_AVG_MAX) ? `ASQ_AVG_MAX : avg_q;
  wire [6:0] avg_need = 7'd1 << avg_n;
  wire got = lb_q ? state_q[2] : (state_q[2] & conv_done);
  wire [RES_W-1:0] res = lb_q ? lbv_q : conv_result;
  wire [15:0] acc_sum = acc_q + {{(16-RES_W){1'b0}}, res};
  wire [15:0] avg_v = acc_q >> avg_n;
  wire last = ct_nib[`ASQ_CTL_END]
    || ({1'b0, step_q} == seq_depth(cur_q) - 4'd1);
  wire push = state_q[3];
  wire push_ok = push && cnt_q[cur_q] < seq_depth(cur_q);
  wire pop_req = rd && in_seq && asub == `ASQ_SUB_FIFO;
  wire pop_ok = pop_req && cnt_q[aseq] != 4'd0;

  // read mux, sampled into prdata in the setup cycle
  reg [31:0] rd_v;
  always @* begin
    rd_v = 32'h0;
    if (in_seq) begin
      case (asub)
        `ASQ_SUB_MUX: rd_v = mux_q[aseq];
        `ASQ_SUB_CTL: rd_v = ctl_q[aseq];
        `ASQ_SUB_FIFO: rd_v = {{(32-RES_W){1'b0}},
          mem_q[{aseq, head_q[aseq]}]};
        `ASQ_SUB_STAT: begin
          rd_v[2:0] = tail_q[aseq];
          rd_v[6:4] = head_q[aseq];
          rd_v[`ASQ_ST_EMPTY] = cnt_q[aseq] == 4'd0;
          rd_v[`ASQ_ST_FULL] = cnt_q[aseq] == seq_depth(aseq);
        end
        default: rd_v = 32'h0;
      endcase
    end else begin
      case (paddr)
        `ASQ_OFF_ACT: rd_v[3:0] = act_q;
        `ASQ_OFF_RIS: rd_v[3:0] = ris_q;
        `ASQ_OFF_IM: rd_v[3:0] = im_q;
        `ASQ_OFF_ISC: rd_v[3:0] = ris_q & im_q;
        `ASQ_OFF_OVF: rd_v[3:0] = ovf_q;
        `ASQ_OFF_TRIG: rd_v[15:0] = trig_q;
        `ASQ_OFF_UNF: rd_v[3:0] = unf_q;
        `ASQ_OFF_PRI: rd_v[15:0] = pri_q;
        `ASQ_OFF_AVG: rd_v[2:0] = avg_q;
        `ASQ_OFF_LB: rd_v[0] = lb_q;
        default: rd_v = 32'h0;
      endcase
    end
  end

  wire mapped = in_seq || paddr == `ASQ_OFF_ACT || paddr == `ASQ_OFF_RIS
    || paddr == `ASQ_OFF_IM || paddr == `ASQ_OFF_ISC
    || paddr == `ASQ_OFF_OVF || paddr == `ASQ_OFF_TRIG
    || paddr == `ASQ_OFF_UNF || paddr == `ASQ_OFF_PRI
    || paddr == `ASQ_OFF_INIT || paddr == `ASQ_OFF_AVG
    || paddr == `ASQ_OFF_LB;
  assign pslverr = acc_ph & ~mapped;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (setup && !pwrite)
      prdata <= rd_v;
  end

  // register file
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= 4'h0;
      im_q <= 4'h0;
      trig_q <= 16'h0;
      pri_q <= `ASQ_PRI_RST;
      avg_q <= 3'h0;
      lb_q <= 1'b0;
      for (ri = 0; ri < 4; ri = ri + 1) begin
        mux_q[ri] <= 32'h0;
        ctl_q[ri] <= (ri == 3) ? `ASQ_CTL3_RST : 32'h0;
      end
    end else if (wr) begin
      // config writes are taken whether enabled or not
      if (in_seq && asub == `ASQ_SUB_MUX)
        mux_q[aseq] <= pwdata;
      if (in_seq && asub == `ASQ_SUB_CTL)
        ctl_q[aseq] <= pwdata;
      case (paddr)
        `ASQ_OFF_ACT: act_q <= pwdata[3:0];
        `ASQ_OFF_IM: im_q <= pwdata[3:0];
        `ASQ_OFF_TRIG: trig_q <= pwdata[15:0];
        `ASQ_OFF_PRI: pri_q <= pwdata[15:0] & `ASQ_PRI_MASK;
        `ASQ_OFF_AVG: avg_q <= pwdata[2:0];
        `ASQ_OFF_LB: lb_q <= pwdata[0];
        default: act_q <= act_q;
      endcase
    end
  end

  // sticky status flags: hardware set wins over a clearing write
  wire [3:0] cur_hot = 4'd1 << cur_q;
  wire [3:0] ris_set = (push && ct_nib[`ASQ_CTL_IE]) ? cur_hot : 4'h0;
  wire [3:0] ovf_set = (push && !push_ok) ? cur_hot : 4'h0;
  wire [3:0] unf_set = (pop_req && !pop_ok) ? (4'd1 << aseq) : 4'h0;
  wire [3:0] isc_clr = (wr && paddr == `ASQ_OFF_ISC) ? pwdata[3:0] : 4'h0;
  wire [3:0] ovf_clr = (wr && paddr == `ASQ_OFF_OVF) ? pwdata[3:0] : 4'h0;
  wire [3:0] unf_clr = (wr && paddr == `ASQ_OFF_UNF) ? pwdata[3:0] : 4'h0;
  wire [3:0] done_clr = (state_q[3] && last) ? cur_hot : 4'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ris_q <= 4'h0;
      ovf_q <= 4'h0;
      unf_q <= 4'h0;
      pend_q <= 4'h0;
    end else begin
      ris_q <= (ris_q & ~(isc_clr & im_q)) | ris_set;
      ovf_q <= (ovf_q & ~ovf_clr) | ovf_set;
      unf_q <= (unf_q & ~unf_clr) | unf_set;
      pend_q <= (pend_q & ~done_clr) | (trig_v & act_q);
    end
  end

  assign irq = |(ris_q & im_q);

  // circular result fifos, one slice of eight slots per sequencer
  wire [3:0] push_hot = push_ok ? cur_hot : 4'h0;
  wire [3:0] pop_hot = pop_ok ? (4'd1 << aseq) : 4'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (fi = 0; fi < 4; fi = fi + 1) begin
        head_q[fi] <= 3'h0;
        tail_q[fi] <= 3'h0;
        cnt_q[fi] <= 4'h0;
      end
    end else begin
      for (fi = 0; fi < 4; fi = fi + 1) begin
        if (push_hot[fi])
          tail_q[fi] <= (tail_q[fi] == seq_depth(fi[1:0]) - 4'd1) ?
            3'h0 : tail_q[fi] + 3'h1;
        if (pop_hot[fi])
          head_q[fi] <= (head_q[fi] == seq_depth(fi[1:0]) - 4'd1) ?
            3'h0 : head_q[fi] + 3'h1;
        cnt_q[fi] <= cnt_q[fi] + {3'h0, push_hot[fi]}
          - {3'h0, pop_hot[fi]};
      end
    end
  end

  always @(posedge pclk) begin
    if (push_ok)
      mem_q[{cur_q, tail_q[cur_q]}] <= avg_v[RES_W-1:0];
  end

  // step engine: one converter shared by all sequencers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cur_q <= 2'd0;
      step_q <= 3'd0;
      avgc_q <= 7'd0;
      acc_q <= 16'h0;
      lbv_q <= {RES_W{1'b0}};
      conv_start <= 1'b0;
      conv_input <= 4'h0;
      conv_diff <= 1'b0;
      conv_temp <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (found) begin
            cur_q <= win;
            step_q <= 3'd0;
            avgc_q <= 7'd0;
            acc_q <= 16'h0;
            state_q <= ST_START;
          end
        end
        ST_START: begin
          // diff pair k drives inputs 2k and 2k+1
          conv_input <= ct_nib[`ASQ_CTL_DIFF] ?
            {in_nib[2:0], 1'b0} : in_nib;
          conv_diff <= ct_nib[`ASQ_CTL_DIFF];
          conv_temp <= ct_nib[`ASQ_CTL_TEMP];
          conv_start <= ~lb_q;
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (got) begin
            acc_q <= acc_sum;
            if (lb_q)
              lbv_q <= lbv_q + {{(RES_W-1){1'b0}}, 1'b1};
            if (avgc_q == avg_need - 7'd1) begin
              state_q <= ST_STORE;
            end else begin
              avgc_q <= avgc_q + 7'd1;
              state_q <= ST_START;
            end
          end
        end
        ST_STORE: begin
          avgc_q <= 7'd0;
          acc_q <= 16'h0;
          if (last) begin
            state_q <= ST_IDLE;
          end else begin
            step_q <= step_q + 3'd1;
            state_q <= ST_START;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- asq_monitor.sv ----
// port checker for the sample sequencer control block
// bound into asq_ctrl from tb_top; tracks mask, enable, loopback writes
`timescale 1ns/100ps
`default_nettype none
`include "asq_consts.vh"
module asq_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_start,
  input wire logic [3:0] conv_input,
  input wire logic conv_diff,
  input wire logic conv_done,
  input wire logic irq
);
  logic [3:0] mask_q, act_q;
  logic lb_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadows only what the apb access edge commits
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= 4'h0;
      act_q <= 4'h0;
      lb_q <= 1'b0;
    end else if (psel && penable && pwrite) begin
      if (paddr == `ASQ_OFF_IM) mask_q <= pwdata[3:0];
      if (paddr == `ASQ_OFF_ACT) act_q <= pwdata[3:0];
      if (paddr == `ASQ_OFF_LB) lb_q <= pwdata[0];
    end
  end
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_unmapped: assert property (psel && penable && paddr == 12'h01c
    |-> pslverr) else $error("unmapped access without error");
  chk_rdata_hold: assert property (!(psel && !penable && !pwrite)
    |=> $stable(prdata)) else $error("read data moved");
  chk_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  chk_start_gap: assert property (conv_done |-> !conv_start [*2])
    else $error("start too soon after done");
  chk_step_hold: assert property (conv_start |=> $stable(conv_input) &&
    $stable(conv_diff)) else $error("step select moved");
  chk_diff_pair: assert property (conv_start && conv_diff
    |-> !conv_input[0]) else $error("odd input on differential step");
  chk_off_quiet: assert property (act_q == 4'h0 [*8] |-> !conv_start)
    else $error("start while all sequencers off");
  chk_loop_quiet: assert property (lb_q |-> !conv_start)
    else $error("core started in loopback");
  chk_irq_masked: assert property (mask_q == 4'h0 |-> !irq)
    else $error("interrupt with all masks clear");
endmodule
`default_nettype wire

// ---- asq_core_model.sv ----
// behavioural converter core: one done pulse per start after a lag
// lag set by the bench; code depends only on input and mode
`timescale 1ns/100ps
`default_nettype none
module asq_core_model (
  input wire logic pclk,
  input wire logic conv_start,
  input wire logic [3:0] conv_input,
  input wire logic conv_diff,
  input wire logic [2:0] lag,
  output logic conv_done,
  output logic [9:0] conv_result
);
  logic [3:0] cnt_q;
  logic [9:0] res_q;
  initial begin
    conv_done = 1'b0;
    cnt_q = 4'h0;
    res_q = 10'h000;
  end
  always @(posedge pclk) begin
    conv_done <= 1'b0;
    if (conv_start) begin
      cnt_q <= {1'b0, lag} + 4'h1;
      res_q <= conv_diff ? 10'h1ff + {6'h0, conv_input}
        : {conv_input, 6'h2b};
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      conv_done <= (cnt_q == 4'h1);
    end
  end
  // released line shows the inverse so a stale sample cannot match
  assign conv_result = conv_done ? res_q : ~res_q;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// bench for asq_ctrl: apb master, trigger pulses, core model
// assumes zero-wait apb and a core that answers every start
`timescale 1ns/100ps
`default_nettype none
`include "asq_consts.vh"
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, df;
  logic conv_start, conv_diff, conv_temp, conv_done, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, mux, ctl, seed = 32'h36;
  logic [3:0] trig_in = 4'h0, conv_input, nib;
  logic [9:0] conv_result;
  logic [9:0] ex [8];
  logic [2:0] lag = 3'h0;
  int n_errors = 0, comparisons = 0, nst = 0, cyc = 0, b, k, d, i, n;
  asq_ctrl i_asq_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in(trig_in), .conv_start(conv_start), .conv_input(conv_input),
    .conv_diff(conv_diff), .conv_temp(conv_temp), .conv_done(conv_done),
    .conv_result(conv_result), .irq(irq));
  asq_core_model i_asq_core_model (.pclk(pclk), .conv_start(conv_start),
    .conv_input(conv_input), .conv_diff(conv_diff), .lag(lag),
    .conv_done(conv_done), .conv_result(conv_result));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [9:0] code(logic [3:0] v, logic dm);
    return dm ? 10'h1ff + {5'h0, v, 1'b0} : {v, 6'h2b};
  endfunction
  function automatic logic [11:0] sa(int s, int sub);
    return 12'h040 + 12'(32 * s + 4 * sub);
  endfunction
  task results;
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(logic [11:0] a, logic w, logic [31:0] dat);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge: the next call never reassigns psel in this step
    @(posedge pclk);
  endtask
  task automatic rc(logic [11:0] a, logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(r, e);
  endtask
  task wirq;
    while (irq !== 1'b1) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (conv_start === 1'b1) nst <= nst + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(`ASQ_OFF_PRI, 32'h3210);
    rc(sa(3, 1), 32'h2);
    for (n = 0; n < 4; n++) rc(sa(n, 3), 32'h100);
    rc(`ASQ_OFF_AVG, 32'h0);
    rc(12'h01c, 32'h0);
    for (n = 0; n < 4; n++) begin
      d = (n == 0) ? 8 : (n == 3) ? 1 : 4;
      k = (n == 0) ? 8 : 1 + rnd() % d;
      mux = rnd();
      ctl = rnd();
      for (i = 0; i < k; i++) begin
        r = rnd();
        df = r[0];
        nib = df ? {2'b00, r[2:1]} : r[6:3];
        mux[4*i+:4] = nib;
        ctl[4*i+:4] = {1'b0, i == k - 1, i == k - 1, df};
        ex[i] = code(nib, df);
      end
      lag <= r[10:8];
      apb(`ASQ_OFF_TRIG, 1'b1, (n == 1 ? 32'h1 : 32'h0) << 4 * n);
      apb(sa(n, 0), 1'b1, mux);
      apb(sa(n, 1), 1'b1, ctl);
      apb(`ASQ_OFF_IM, 1'b1, 32'h1 << n);
      apb(`ASQ_OFF_ACT, 1'b1, 32'h1 << n);
      b = nst;
      if (n == 1) begin
        trig_in <= 4'h2;
        @(posedge pclk);
        trig_in <= 4'h0;
      end else
        apb(`ASQ_OFF_INIT, 1'b1, 32'h1 << n);
      wirq;
      chk(nst - b, k);
      apb(sa(n, 3), 1'b0, 32'h0);
      chk({r[12], r[8]}, {k == d, 1'b0});
      for (i = 0; i < k; i++) rc(sa(n, 2), {22'h0, ex[i]});
      apb(sa(n, 3), 1'b0, 32'h0);
      chk(r[8], 1'b1);
      rc(`ASQ_OFF_RIS, 32'h1 << n);
      rc(`ASQ_OFF_ISC, 32'h1 << n);
      chk(irq, 1'b1);
      apb(`ASQ_OFF_ISC, 1'b1, 32'h0);
      rc(`ASQ_OFF_RIS, 32'h1 << n);
      apb(`ASQ_OFF_ISC, 1'b1, 32'h1 << n);
      rc(`ASQ_OFF_RIS, 32'h0);
      chk(irq, 1'b0);
      apb(sa(n, 2), 1'b0, 32'h0);
      rc(`ASQ_OFF_UNF, 32'h1 << n);
      apb(`ASQ_OFF_UNF, 1'b1, 32'h1 << n);
      apb(`ASQ_OFF_ACT, 1'b1, 32'h0);
    end
    // count field above six must saturate at 64 conversions
    apb(`ASQ_OFF_AVG, 1'b1, 32'h7);
    apb(sa(3, 0), 1'b1, 32'h7);
    apb(sa(3, 1), 1'b1, 32'h6);
    apb(`ASQ_OFF_IM, 1'b1, 32'h8);
    apb(`ASQ_OFF_ACT, 1'b1, 32'h8);
    b = nst;
    apb(`ASQ_OFF_INIT, 1'b1, 32'h8);
    wirq;
    chk(nst - b, 64);
    rc(sa(3, 2), {22'h0, code(4'h7, 1'b0)});
    apb(`ASQ_OFF_ISC, 1'b1, 32'h8);
    apb(`ASQ_OFF_AVG, 1'b1, 32'h0);
    apb(`ASQ_OFF_IM, 1'b1, 32'h0);
    apb(`ASQ_OFF_LB, 1'b1, 32'h1);
    b = nst;
    apb(`ASQ_OFF_INIT, 1'b1, 32'h8);
    r = 32'h100;
    while (r[8]) apb(sa(3, 3), 1'b0, 32'h0);
    chk(nst - b, 0);
    chk(irq, 1'b0);
    rc(`ASQ_OFF_RIS, 32'h8);
    rc(`ASQ_OFF_ISC, 32'h0);
    rc(sa(3, 2), 32'h0);
    apb(`ASQ_OFF_LB, 1'b1, 32'h0);
    b = nst;
    apb(`ASQ_OFF_TRIG, 1'b1, 32'hf000);
    while (nst - b < 4) @(posedge pclk);
    apb(`ASQ_OFF_ACT, 1'b1, 32'h0);
    rc(`ASQ_OFF_OVF, 32'h8);
    apb(`ASQ_OFF_TRIG, 1'b1, 32'h0);
    apb(`ASQ_OFF_PRI, 1'b1, 32'h3012);
    rc(`ASQ_OFF_PRI, 32'h3012);
    apb(sa(1, 0), 1'b1, 32'h5);
    apb(sa(2, 0), 1'b1, 32'h9);
    apb(sa(1, 1), 1'b1, 32'h2);
    apb(sa(2, 1), 1'b1, 32'ha);
    apb(`ASQ_OFF_ACT, 1'b1, 32'h6);
    apb(`ASQ_OFF_INIT, 1'b1, 32'h6);
    @(posedge conv_start);
    #1;
    chk(conv_input, 4'h9);
    chk(conv_temp, 1'b1);
    results;
  end
endmodule
bind asq_ctrl asq_monitor i_asq_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .conv_start(conv_start), .conv_input(conv_input),
  .conv_diff(conv_diff), .conv_done(conv_done), .irq(irq));
`default_nettype wire
